// ### common/eac_map.svh
// Register offsets, field positions and timing constants of the controller
`ifndef EAC_MAP_SVH
`define EAC_MAP_SVH
`define EAC_REG_ADDR_LOW   2'h0
`define EAC_REG_ADDR_HIGH  2'h1
`define EAC_REG_DATA       2'h2
`define EAC_REG_CONTROL    2'h3
`define EAC_BIT_READ       0
`define EAC_BIT_WRITE      1
`define EAC_BIT_ARM        2
`define EAC_BIT_IRQ_EN     3
`define EAC_DEPTH          512
`define EAC_ARM_CYCLES     3'h4
`define EAC_WRITE_STALL    3'h2
`define EAC_READ_STALL     3'h4
`define EAC_WRITE_OSC_CYC  17'h10800
`endif

// ### common/eac_pkg.sv
// Types shared by both ends of the controller
package eac_pkg;
  typedef logic [1:0] eac_reg_t;
  typedef logic [7:0] eac_byte_t;
  typedef logic [8:0] eac_addr_t;
  typedef enum logic [1:0] {
    EAC_IDLE  = 2'b00,
    EAC_WRITE = 2'b01
  } eac_state_e;
endpackage

// ### common/eac_if.sv
// Register access interface between the core and the controller
`timescale 1ns/1ps
interface eac_if;
  import eac_pkg::*;
  logic      io_write;
  logic      io_read;
  eac_reg_t  io_reg;
  eac_byte_t io_wdata;
  eac_byte_t io_rdata;
  logic      core_stall;
  logic      ready_irq;
  modport device (input io_write, io_read, io_reg, io_wdata,
                  output io_rdata, core_stall, ready_irq);
  modport core (output io_write, io_read, io_reg, io_wdata,
                input io_rdata, core_stall, ready_irq);
endinterface

// ### design/eac_device.sv
// Byte-wide data store access controller, device end
`timescale 1ns/1ps
`include "eac_map.svh"
module eac_device (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       nrst_in,
  // Core register port
  eac_if.device           bus,
  // System side
  input  wire logic       global_irq_en_in,
  input  wire logic       flash_selfprog_busy_in,
  input  wire logic       osc_in,
  output logic            write_done_out
);
  import eac_pkg::*;

  // ****************************************
  // Storage and registers
  // ****************************************
  eac_byte_t  mem [`EAC_DEPTH];
  eac_addr_t  nv_byte_address;
  eac_byte_t  nv_byte_data;
  logic       ready_irq_enable;
  logic       write_arm_enable;
  logic [2:0] arm_count;
  logic [2:0] stall_count;
  eac_state_e state;
  logic [16:0] osc_count;
  logic       osc_meta;
  logic       osc_sync;
  logic       osc_last;
  logic       osc_tick;
  logic       ctrl_wr;
  logic       start_write;
  logic       start_read;

  assign ctrl_wr = bus.io_write && bus.io_reg == `EAC_REG_CONTROL;
  // Write has priority over a simultaneous read strobe
  assign start_write = ctrl_wr && state == EAC_IDLE && write_arm_enable
    && bus.io_wdata[`EAC_BIT_WRITE] && !flash_selfprog_busy_in;
  assign start_read = ctrl_wr && state == EAC_IDLE && !start_write
    && bus.io_wdata[`EAC_BIT_READ];

  // ****************************************
  // Oscillator sampling
  // ****************************************
  // Oscillator is a foreign clock, so it passes two flops first
  always_ff @(posedge clock_in) begin
    osc_meta <= osc_in;
    osc_sync <= osc_meta;
    osc_last <= osc_sync;
  end
  assign osc_tick = osc_sync && !osc_last;

  // ****************************************
  // Address and data
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (bus.io_write && state == EAC_IDLE) begin
      if (bus.io_reg == `EAC_REG_ADDR_LOW) begin
        nv_byte_address[7:0] <= bus.io_wdata;
      end
      if (bus.io_reg == `EAC_REG_ADDR_HIGH) begin
        nv_byte_address[8] <= bus.io_wdata[0];
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (start_read) begin
      nv_byte_data <= mem[nv_byte_address];
    end else if (bus.io_write && bus.io_reg == `EAC_REG_DATA) begin
      nv_byte_data <= bus.io_wdata;
    end
  end

  always_ff @(posedge clock_in) begin
    if (start_write) begin
      mem[nv_byte_address] <= nv_byte_data;
    end
  end

  // ****************************************
  // Control bits
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      ready_irq_enable <= 1'b0;
    end else if (ctrl_wr) begin
      ready_irq_enable <= bus.io_wdata[`EAC_BIT_IRQ_EN];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      write_arm_enable <= 1'b0;
      arm_count        <= 3'h0;
    end else if (ctrl_wr && bus.io_wdata[`EAC_BIT_ARM]) begin
      write_arm_enable <= 1'b1;
      arm_count        <= `EAC_ARM_CYCLES;
    end else if (arm_count == 3'h1 || start_write) begin
      write_arm_enable <= 1'b0;
      arm_count        <= 3'h0;
    end else if (arm_count != 3'h0) begin
      arm_count <= arm_count - 3'h1;
    end
  end

  // ****************************************
  // Write timing
  // ****************************************
  // No reset here: a write in flight finishes across a reset
  always_ff @(posedge clock_in) begin
    write_done_out <= 1'b0;
    if (start_write) begin
      state     <= EAC_WRITE;
      osc_count <= `EAC_WRITE_OSC_CYC;
    end else begin
      unique case (state)
        EAC_IDLE: begin
          osc_count <= 17'h0;
        end
        EAC_WRITE: begin
          if (osc_tick) begin
            osc_count <= osc_count - 17'h1;
            if (osc_count == 17'h1) begin
              state          <= EAC_IDLE;
              write_done_out <= 1'b1;
            end
          end
        end
        default: begin
          state <= EAC_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Core stall
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      stall_count <= 3'h0;
    end else if (start_write) begin
      stall_count <= `EAC_WRITE_STALL;
    end else if (start_read) begin
      stall_count <= `EAC_READ_STALL;
    end else if (stall_count != 3'h0) begin
      stall_count <= stall_count - 3'h1;
    end
  end
  assign bus.core_stall = stall_count != 3'h0;

  // ****************************************
  // Read back and interrupt
  // ****************************************
  always_comb begin
    unique case (bus.io_reg)
      `EAC_REG_ADDR_LOW:  bus.io_rdata = nv_byte_address[7:0];
      `EAC_REG_ADDR_HIGH: bus.io_rdata = {7'h00, nv_byte_address[8]};
      `EAC_REG_DATA:      bus.io_rdata = nv_byte_data;
      `EAC_REG_CONTROL:   bus.io_rdata = {4'h0, ready_irq_enable,
        write_arm_enable, state == EAC_WRITE, 1'b0};
      default:            bus.io_rdata = 8'h00;
    endcase
  end
  assign bus.ready_irq = ready_irq_enable && global_irq_en_in
    && state == EAC_IDLE;
endmodule // eac_device

// ### design/eac_core.sv
// Core-side sequencer driving the controller's registers
`timescale 1ns/1ps
`include "eac_map.svh"
module eac_core (
  // Clock and reset
  input  wire logic             clock_in,
  input  wire logic             nrst_in,
  // Controller port
  eac_if.core                   bus,
  // User requests
  input  wire logic             write_req_in,
  input  wire logic             read_req_in,
  input  wire eac_pkg::eac_addr_t addr_in,
  input  wire eac_pkg::eac_byte_t data_in,
  input  wire logic             flash_selfprog_busy_in,
  output logic                  busy_out,
  output logic                  read_valid_out,
  output eac_pkg::eac_byte_t    read_data_out
);
  import eac_pkg::*;

  // ****************************************
  // Sequencer
  // ****************************************
  typedef enum logic [3:0] {
    EAC_C_IDLE = 4'h0, EAC_C_POLL = 4'h1, EAC_C_ALO = 4'h2,
    EAC_C_AHI  = 4'h3, EAC_C_DAT  = 4'h4, EAC_C_ARM = 4'h5,
    EAC_C_STB  = 4'h6, EAC_C_WAIT = 4'h7, EAC_C_GET = 4'h8
  } eac_core_e;
  eac_core_e  st;
  logic       is_read;
  eac_addr_t  addr;
  eac_byte_t  data;
  logic       busy_seen;

  assign busy_seen = bus.io_rdata[`EAC_BIT_WRITE];

  // Requests are captured in one burst; interrupts play no part here
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      st             <= EAC_C_IDLE;
      is_read        <= 1'b0;
      addr           <= 9'h000;
      data           <= 8'h00;
      read_valid_out <= 1'b0;
      read_data_out  <= 8'h00;
    end else begin
      read_valid_out <= 1'b0;
      if (!bus.core_stall) begin
        unique case (st)
          EAC_C_IDLE: if (write_req_in || read_req_in) begin
            is_read <= !write_req_in;
            addr    <= addr_in;
            data    <= data_in;
            st      <= EAC_C_POLL;
          end
          EAC_C_POLL: if (!busy_seen && !flash_selfprog_busy_in) begin
            st <= EAC_C_ALO;
          end
          EAC_C_ALO: st <= EAC_C_AHI;
          EAC_C_AHI: st <= is_read ? EAC_C_GET : EAC_C_DAT;
          EAC_C_DAT: st <= EAC_C_ARM;
          EAC_C_ARM: st <= EAC_C_STB;
          EAC_C_STB: st <= EAC_C_IDLE;
          EAC_C_GET: st <= EAC_C_WAIT;
          EAC_C_WAIT: begin
            read_valid_out <= 1'b1;
            read_data_out  <= bus.io_rdata;
            st             <= EAC_C_IDLE;
          end
          default: st <= EAC_C_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Register access drive
  // ****************************************
  always_comb begin
    bus.io_write = 1'b0;
    bus.io_read  = 1'b0;
    bus.io_reg   = `EAC_REG_CONTROL;
    bus.io_wdata = 8'h00;
    unique case (st)
      EAC_C_POLL: bus.io_read = 1'b1;
      EAC_C_ALO: begin
        bus.io_write = 1'b1;
        bus.io_reg   = `EAC_REG_ADDR_LOW;
        bus.io_wdata = addr[7:0];
      end
      EAC_C_AHI: begin
        bus.io_write = 1'b1;
        bus.io_reg   = `EAC_REG_ADDR_HIGH;
        bus.io_wdata = {7'h00, addr[8]};
      end
      EAC_C_DAT: begin
        bus.io_write = 1'b1;
        bus.io_reg   = `EAC_REG_DATA;
        bus.io_wdata = data;
      end
      EAC_C_ARM: begin
        bus.io_write = 1'b1;
        bus.io_wdata[`EAC_BIT_ARM] = 1'b1;
      end
      EAC_C_STB: begin
        bus.io_write = 1'b1;
        bus.io_wdata[`EAC_BIT_WRITE] = 1'b1;
      end
      EAC_C_GET: begin
        bus.io_write = 1'b1;
        bus.io_wdata[`EAC_BIT_READ] = 1'b1;
      end
      EAC_C_WAIT: begin
        bus.io_read = 1'b1;
        bus.io_reg  = `EAC_REG_DATA;
      end
      default: begin
        bus.io_write = 1'b0;
      end
    endcase
  end
  assign busy_out = st != EAC_C_IDLE;
endmodule // eac_core

// ### tb/eac_properties.sv
// Concurrent checks on the core-to-controller register interface
`timescale 1ns/1ps
module eac_properties (
  // Clock and reset
  input wire logic              clock_in,
  input wire logic              nrst_in,
  // Interface signals
  input wire logic              io_write,
  input wire logic              io_read,
  input wire eac_pkg::eac_reg_t  io_reg,
  input wire eac_pkg::eac_byte_t io_wdata,
  input wire eac_pkg::eac_byte_t io_rdata,
  input wire logic              core_stall,
  input wire logic              ready_irq
);
  import eac_pkg::*;
  // ****************************************
  // Shadow of arm and busy state
  // ****************************************
  logic       armed;
  logic [2:0] arm_age;
  logic       wr_busy;
  logic [9:0] run_age;
  wire logic ctl_wr = io_write && io_reg == 2'h3;
  wire logic ctl_rd = io_read && io_reg == 2'h3;
  // Late strobes skipped: the edge-four race is left to the device
  wire logic launch = ctl_wr && io_wdata[1] && armed && arm_age < 3'h3
                      && !wr_busy;
  wire logic rd_go = ctl_wr && io_wdata[1:0] == 2'h1 && !wr_busy;
  wire logic go_any = launch || rd_go;
  always_ff @(posedge clock_in) begin
    if (!nrst_in || launch) begin
      armed   <= 1'b0;
      arm_age <= 3'h0;
    end else if (ctl_wr && io_wdata[2] && !io_wdata[1]) begin
      armed   <= 1'b1;
      arm_age <= 3'h0;
    end else if (arm_age != 3'h7) begin
      arm_age <= arm_age + 3'h1;
    end
  end
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      wr_busy <= 1'b0;
    end else if (launch) begin
      wr_busy <= 1'b1;
    end else if (ctl_rd && !io_rdata[1]) begin
      wr_busy <= 1'b0;
    end
  end
  always_ff @(posedge clock_in) begin
    if (launch) begin
      run_age <= 10'h000;
    end else if (run_age != 10'h3FF) begin
      run_age <= run_age + 10'h001;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  sequence stall2_s; core_stall [*2] ##1 !core_stall; endsequence
  sequence stall4_s; core_stall [*4] ##1 !core_stall; endsequence
  a_write_stall_two: assert property (
    launch |=> stall2_s) else $error("write stall length wrong");
  a_read_stall_four: assert property (
    rd_go |=> stall4_s) else $error("read stall length wrong");
  a_stall_has_cause: assert property (
    $rose(core_stall) |-> $past(go_any)) else $error("stray stall");
  a_ctrl_top_zero: assert property (
    ctl_rd |-> io_rdata[7:4] == 4'h0) else $error("control top bits set");
  a_addr_top_zero: assert property (
    io_read && io_reg == 2'h1 |-> io_rdata[7:1] == 7'h00)
    else $error("address top bits set");
  a_arm_expires: assert property (
    ctl_rd && (!armed || arm_age >= 3'h4) |-> !io_rdata[2])
    else $error("arm bit stuck");
  a_busy_shown: assert property (
    ctl_rd && wr_busy && run_age < 10'h3E8 |-> io_rdata[1])
    else $error("busy bit missing");
  a_irq_not_busy: assert property (
    ctl_rd && io_rdata[1] |-> !ready_irq) else $error("irq while busy");
endmodule // eac_properties

// ### tb/eeprom_access_controller_tb.sv
// Self-checking bench joining the core sequencer and the controller
`timescale 1ns/1ps
module eeprom_access_controller_tb;
  import eac_pkg::*;
  logic      clock_in, nrst_in, osc, wr_req, rd_req, busy, rvalid, wdone;
  eac_addr_t addr;
  eac_byte_t wdat, rdat, got;
  int        mismatches = 0, checks_done = 0, done_cnt = 0, stall_cnt = 0;
  eac_if bus_if ();
  eac_core u_eac_core (.clock_in(clock_in), .nrst_in(nrst_in),
    .bus(bus_if), .write_req_in(wr_req), .read_req_in(rd_req),
    .addr_in(addr), .data_in(wdat), .flash_selfprog_busy_in(1'b0),
    .busy_out(busy), .read_valid_out(rvalid), .read_data_out(rdat));
  eac_device u_eac_device (.clock_in(clock_in), .nrst_in(nrst_in),
    .bus(bus_if), .global_irq_en_in(1'b1), .flash_selfprog_busy_in(1'b0),
    .osc_in(osc), .write_done_out(wdone));
  eac_properties u_eac_properties (.clock_in(clock_in), .nrst_in(nrst_in),
    .io_write(bus_if.io_write), .io_read(bus_if.io_read),
    .io_reg(bus_if.io_reg), .io_wdata(bus_if.io_wdata),
    .io_rdata(bus_if.io_rdata), .core_stall(bus_if.core_stall),
    .ready_irq(bus_if.ready_irq));
  // ****************************************
  // Clocks and monitors
  // ****************************************
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  // Oscillator off the clock phase; a full write still takes 135k cycles
  initial begin
    osc = 1'b0;
    #7;
    forever #25 osc = ~osc;
  end
  always @(posedge clock_in) begin
    if (wdone === 1'b1) done_cnt++;
    if (bus_if.core_stall === 1'b1) stall_cnt++;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk8(input string what, input eac_byte_t e, eac_byte_t s);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", what, e, s);
    end
  endtask
  task automatic chkn(input string what, input int e, input int s);
    checks_done++;
    if (s != e) begin
      mismatches++;
      $display("BAD %s exp %0d got %0d", what, e, s);
    end
  endtask
  task automatic xfer(input logic wr, input eac_addr_t a, eac_byte_t d);
    int n;
    n = 0;
    addr <= a;
    wdat <= d;
    wr_req <= wr;
    rd_req <= !wr;
    while (n < 140000) begin
      @(posedge clock_in);
      n++;
      if (busy === 1'b1) begin
        wr_req <= 1'b0;
        rd_req <= 1'b0;
      end
      if ((wr ? wdone : rvalid) === 1'b1) break;
    end
    got = rdat;
    chkn("transfer finished", 1, int'(n < 140000));
    @(posedge clock_in);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ****************************************
  // Sequence and watchdog
  // ****************************************
  initial begin
    nrst_in = 1'b0;
    wr_req = 1'b0;
    rd_req = 1'b0;
    addr = 9'h000;
    wdat = 8'h00;
    repeat (10) @(posedge clock_in);
    nrst_in <= 1'b1;
    @(posedge clock_in);
    chk8("irq after reset", 8'h00, {7'h00, bus_if.ready_irq});
    xfer(1'b1, 9'h1FF, 8'hA5);
    chkn("write done", 1, done_cnt);
    chk8("irq after mid reset", 8'h00, {7'h00, bus_if.ready_irq});
    chkn("write stall", 2, stall_cnt);
    xfer(1'b0, 9'h1FF, 8'h00);
    chk8("read back", 8'hA5, got);
    xfer(1'b0, 9'h1FF, 8'h00);
    chk8("read again", 8'hA5, got);
    repeat (8) @(posedge clock_in);
    chkn("read stall", 10, stall_cnt);
    test_done;
  end
  // Reset pulse in mid-write: the write in flight must still finish
  initial begin
    wait (stall_cnt == 2);
    repeat (100) @(posedge clock_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    nrst_in <= 1'b1;
  end
  initial begin
    #4000000;
    mismatches++;
    $display("BAD watchdog exp done got hang");
    test_done;
  end
endmodule // eeprom_access_controller_tb
